// *** design/sci_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sci_regs.svh"
// Contract
// - A software command performs the same acknowledge as the hardware strobe.
// - Interrupt request pin is pulled low when a pending bit with no under-service bit at or above it is set and chain input high.
// - A pending bit never sets while its source enable is clear.
// - All six pending bits are read back through one status register.
// - A set under-service bit blocks all lower priority sources inside and outside.
// - Inner sources blocked by the internal chain; outer ones by chain output low.
// - Acknowledge sets under-service of highest pending source only if chain input high.
// - Channel A above B; receive above transmit above external/status.
// - Transmit level clear: interrupt when top transmit FIFO entry empties.
// - Transmit level set: interrupt only when FIFO fully empty after a write.
// - Receive modes: first character, every character, or special condition only.
// - Receive level set: character interrupt only with four or more bytes waiting.
// - Overrun, framing, end of frame and optional parity are special conditions.
// - Special condition differs from character interrupt only in vector status.
// - First character mode: special conditions interrupt any time after first character.
// - External/status interrupt on input transitions, underrun, zero count, break/abort/poll.
// - Abort or end-of-poll interrupts both at start and at end of the sequence.
// - Control bits select wait function or DMA request function for the output.
// - DMA mode: request asserted while ready to move data.
// - CPU block mode: wait asserted while not ready to transfer.
// - Second request timing bit set: second request deasserts when the top transmit entry is not empty or request enable is clear.
// - Master enable clear suppresses all interrupt requests.
// - Chain output high only when chain input high and not servicing or requesting in ack.
// - An acknowledge releases the interrupt request output.
// - Vector read through channel A has no status; through channel B always has it.
module sci_irq_ctrl
	import sci_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic chain_enable_input,
	output logic chain_enable_output,
	input wire logic irq_acknowledge_n,
	output logic irq_n_o,
	output logic irq_n_oe,
	input wire logic [1:0] rx_char_avail,
	input wire logic [5:0] rx_fifo_count,
	input wire logic [1:0] rx_overrun,
	input wire logic [1:0] rx_framing_err,
	input wire logic [1:0] rx_end_of_frame,
	input wire logic [1:0] rx_parity_err,
	input wire logic [1:0] tx_top_empty,
	input wire logic [1:0] tx_all_empty,
	input wire logic [1:0] tx_written,
	input wire logic [1:0] cts_n,
	input wire logic [1:0] carrier_detect_input_n,
	input wire logic [1:0] sync_n,
	input wire logic [1:0] tx_underrun,
	input wire logic [1:0] brg_zero,
	input wire logic [1:0] break_abort_eop,
	output logic [1:0] wait_request_n,
	output logic [1:0] dma_request2_n
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin inputs pass two flip-flops; stage two also feeds a third that holds the previous sample.
	localparam int NPIN = 10;
	logic [NPIN-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q;
	assign pin_raw = {irq_acknowledge_n, chain_enable_input, cts_n, carrier_detect_input_n, sync_n,
		break_abort_eop};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			pin_s3_q <= '1;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	logic ack_n_s, iei_s;
	logic [1:0] cts_s, dcd_s, sync_s, bae_s, cts_p, dcd_p, sync_p, bae_p;
	assign {ack_n_s, iei_s, cts_s, dcd_s, sync_s, bae_s} = pin_s2_q;
	assign {cts_p, dcd_p, sync_p, bae_p} = pin_s3_q[7:0];

	logic [7:0] ctrl_q [2];
	logic [7:0] enh_q [2];
	logic [7:0] master_q, vector_q;
	logic [5:0] ip_q, ius_q, ip_set;
	logic [1:0] first_seen_q;
	logic soft_ack_q;
	logic wb_req, wb_wr, ack_q, cmd_ius, cmd_ack, cmd_first;
	logic [1:0] cmd_first_ch;
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	assign cmd_ius = wb_wr && wb_adr_i == `SCI_ADDR_COMMAND && wb_dat_i[7:0] == `SCI_CMD_RESET_IUS;
	assign cmd_ack = wb_wr && wb_adr_i == `SCI_ADDR_COMMAND && wb_dat_i[7:0] == `SCI_CMD_SOFT_ACK;
	assign cmd_first = wb_wr && wb_adr_i == `SCI_ADDR_COMMAND && wb_dat_i[7:0] == `SCI_CMD_FIRST_RX;
	assign cmd_first_ch = cmd_first ? {wb_dat_i[8], !wb_dat_i[8]} : 2'b00;

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = a <= `SCI_ADDR_SERVICE && a[1:0] == 2'b00;
	endfunction

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q[0] <= `SCI_RST_CTRL;
			ctrl_q[1] <= `SCI_RST_CTRL;
			enh_q[0] <= `SCI_RST_CTRL;
			enh_q[1] <= `SCI_RST_CTRL;
			master_q <= `SCI_RST_CTRL;
			vector_q <= `SCI_RST_VECTOR;
		end else if (wb_wr) begin
			case (wb_adr_i)
				`SCI_ADDR_CTRL_A: ctrl_q[0] <= wb_dat_i[7:0];
				`SCI_ADDR_CTRL_B: ctrl_q[1] <= wb_dat_i[7:0];
				`SCI_ADDR_ENH_A: enh_q[0] <= wb_dat_i[7:0];
				`SCI_ADDR_ENH_B: enh_q[1] <= wb_dat_i[7:0];
				`SCI_ADDR_MASTER: master_q <= wb_dat_i[7:0];
				`SCI_ADDR_VECTOR: vector_q <= wb_dat_i[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_ack_q <= 1'b0;
		end else begin
			soft_ack_q <= cmd_ack;
		end
	end

	// Source order, highest first: bit 5 A rx, 4 A tx, 3 A ext, 2 B rx, 1 B tx, 0 B ext.
	logic [5:0] ie;
	logic [1:0] special, char_ev, tx_ev, ext_ev;
	logic [1:0] tx_top_d, tx_all_d;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_top_d <= 2'b00;
			tx_all_d <= 2'b00;
		end else begin
			tx_top_d <= tx_top_empty;
			tx_all_d <= tx_all_empty;
		end
	end
	for (genvar c = 0; c < 2; c++) begin : g_ch
		sci_rx_mode_type mode;
		assign mode = sci_rx_mode_type'(ctrl_q[c][`SCI_CTRL_RX_MODE_HI:`SCI_CTRL_RX_MODE_LO]);
		assign ie[5-3*c] = mode != SCI_RX_OFF;
		assign ie[4-3*c] = ctrl_q[c][`SCI_CTRL_TX_IE];
		assign ie[3-3*c] = ctrl_q[c][`SCI_CTRL_EXT_IE];
		assign special[c] = rx_overrun[c] || rx_framing_err[c] || rx_end_of_frame[c] ||
			(ctrl_q[c][`SCI_CTRL_PAR_SPECIAL] && rx_parity_err[c]);
		logic char_ok;
		assign char_ok = enh_q[c][`SCI_ENH_RX_LEVEL] ? rx_fifo_count[3*c+:3] >= `SCI_RX_FULL_LEVEL :
			rx_char_avail[c];
		assign char_ev[c] = char_ok &&
			(mode == SCI_RX_ALL || (mode == SCI_RX_FIRST && !first_seen_q[c]));
		// First-character mode allows special conditions only once the first one arrived.
		logic spec_ok;
		assign spec_ok = mode == SCI_RX_FIRST ? first_seen_q[c] || char_ev[c] : mode != SCI_RX_OFF;
		assign ip_set[5-3*c] = char_ev[c] || (special[c] && spec_ok);
		assign tx_ev[c] = enh_q[c][`SCI_ENH_TX_LEVEL] ? tx_all_empty[c] && !tx_all_d[c] && tx_written[c]
			: tx_top_empty[c] && !tx_top_d[c];
		assign ip_set[4-3*c] = tx_ev[c];
		assign ext_ev[c] = cts_s[c] != cts_p[c] || dcd_s[c] != dcd_p[c] || sync_s[c] != sync_p[c] ||
			tx_underrun[c] || brg_zero[c] || bae_s[c] != bae_p[c];
		assign ip_set[3-3*c] = ext_ev[c];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_seen_q <= 2'b00;
		end else begin
			first_seen_q <= (first_seen_q & ~cmd_first_ch) | char_ev;
		end
	end

	// Pending clears when its source is acknowledged into service; a new event wins.
	logic [5:0] ack_grant;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ip_q <= 6'h00;
		end else begin
			ip_q <= ((ip_q & ~ack_grant) | ip_set) & ie;
		end
	end

	// Internal daisy chain: a source may act only when nothing above is in service.
	logic [6:0] chain_in;
	logic [5:0] req_chain;
	assign chain_in[6] = iei_s;
	for (genvar i = 0; i < 6; i++) begin : g_chain
		assign req_chain[i] = chain_in[i+1] && ip_q[i] && !ius_q[i];
		assign chain_in[i] = chain_in[i+1] && !ius_q[i];
	end
	logic any_req, master_irq_enable;
	assign master_irq_enable = master_q[`SCI_MASTER_MIE];
	assign any_req = master_irq_enable && |req_chain;

	sci_ack_state_type ack_state_q;
	logic ack_start, ack_phase;
	assign ack_start = (!ack_n_s || soft_ack_q) && ack_state_q == SCI_ACK_IDLE;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_state_q <= SCI_ACK_IDLE;
		end else begin
			case (ack_state_q)
				SCI_ACK_IDLE: if (ack_start && !soft_ack_q) ack_state_q <= SCI_ACK_ACTIVE;
				SCI_ACK_ACTIVE: if (ack_n_s) ack_state_q <= SCI_ACK_IDLE;
				default: ack_state_q <= SCI_ACK_IDLE;
			endcase
		end
	end
	assign ack_phase = ack_start || ack_state_q == SCI_ACK_ACTIVE;

	// Highest requesting source, one-hot; several sources can request at once, so the highest bit wins.
	function automatic logic [5:0] top_one(input logic [5:0] v);
		top_one = 6'h00;
		for (int k = 0; k < 6; k++) begin
			if (v[k]) top_one = 6'h00 | (6'h01 << k);
		end
	endfunction
	assign ack_grant = (ack_start && master_irq_enable && iei_s) ? top_one(req_chain) : 6'h00;
	logic [5:0] ius_clear;
	assign ius_clear = cmd_ius ? top_one(ius_q) : 6'h00;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ius_q <= 6'h00;
		end else begin
			ius_q <= (ius_q & ~ius_clear) | ack_grant;
		end
	end

	// Request releases while an acknowledge runs, letting higher devices interrupt.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_oe <= 1'b0;
			chain_enable_output <= 1'b0;
		end else begin
			irq_n_oe <= any_req && !ack_phase;
			chain_enable_output <= chain_in[0] && !(ack_phase && any_req);
		end
	end
	assign irq_n_o = 1'b0;

	// Vector status code of the highest source; special receive gets its own code.
	logic [2:0] vstat;
	always_comb begin
		vstat = 3'd3;
		for (int k = 0; k < 6; k++) begin
			if (ius_q[k] || req_chain[k]) begin
				case (k)
					5: vstat = special[0] ? 3'd7 : 3'd6;
					4: vstat = 3'd4;
					3: vstat = 3'd5;
					2: vstat = special[1] ? 3'd3 : 3'd2;
					1: vstat = 3'd0;
					default: vstat = 3'd1;
				endcase
			end
		end
	end

	logic [7:0] rd_data;
	always_comb begin
		case (wb_adr_i)
			`SCI_ADDR_CTRL_A: rd_data = ctrl_q[0];
			`SCI_ADDR_CTRL_B: rd_data = ctrl_q[1];
			`SCI_ADDR_MASTER: rd_data = master_q;
			`SCI_ADDR_ENH_A: rd_data = enh_q[0];
			`SCI_ADDR_ENH_B: rd_data = enh_q[1];
			`SCI_ADDR_VECTOR: rd_data = vector_q;
			`SCI_ADDR_PEND: rd_data = {2'b00, ip_q};
			`SCI_ADDR_VEC_A: rd_data = vector_q;
			`SCI_ADDR_VEC_B: rd_data = {vector_q[7:4], vstat, vector_q[0]};
			`SCI_ADDR_SERVICE: rd_data = {2'b00, ius_q};
			default: rd_data = 8'h00;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req && addr_known(wb_adr_i);
			wb_err_o <= wb_req && !addr_known(wb_adr_i) && !wb_err_o;
			wb_dat_o <= wb_req ? {24'h00_0000, rd_data} : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;

	// Wait/request: readiness is receive data waiting or transmit room, per control bit.
	for (genvar c = 0; c < 2; c++) begin : g_req
		logic ready;
		assign ready = ctrl_q[c][`SCI_CTRL_REQ_ON_RX] ? rx_char_avail[c] : tx_top_empty[c];
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				wait_request_n[c] <= 1'b1;
				dma_request2_n[c] <= 1'b1;
			end else begin
				if (!ctrl_q[c][`SCI_CTRL_REQ_EN]) begin
					wait_request_n[c] <= 1'b1;
				end else if (ctrl_q[c][`SCI_CTRL_REQ_FUNC]) begin
					wait_request_n[c] <= !ready;
				end else begin
					wait_request_n[c] <= ready;
				end
				if (enh_q[c][`SCI_ENH_DREQ_TIMING]) begin
					dma_request2_n[c] <= !tx_top_empty[c] || !ctrl_q[c][`SCI_CTRL_REQ_EN];
				end else begin
					dma_request2_n[c] <= !tx_all_empty[c];
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** design/sci_regs.svh ***
`ifndef SCI_REGS_SVH
`define SCI_REGS_SVH
// Byte addresses of the Wishbone register words.
`define SCI_ADDR_CTRL_A 8'h00
`define SCI_ADDR_CTRL_B 8'h04
`define SCI_ADDR_MASTER 8'h08
`define SCI_ADDR_ENH_A 8'h0c
`define SCI_ADDR_ENH_B 8'h10
`define SCI_ADDR_VECTOR 8'h14
`define SCI_ADDR_PEND 8'h18
`define SCI_ADDR_COMMAND 8'h1c
`define SCI_ADDR_VEC_A 8'h20
`define SCI_ADDR_VEC_B 8'h24
`define SCI_ADDR_SERVICE 8'h28
// Control register fields (irq_and_transfer_control).
`define SCI_CTRL_EXT_IE 0
`define SCI_CTRL_TX_IE 1
`define SCI_CTRL_PAR_SPECIAL 2
`define SCI_CTRL_RX_MODE_LO 3
`define SCI_CTRL_RX_MODE_HI 4
`define SCI_CTRL_REQ_ON_RX 5
`define SCI_CTRL_REQ_FUNC 6
`define SCI_CTRL_REQ_EN 7
// Enhancement control fields.
`define SCI_ENH_RX_LEVEL 3
`define SCI_ENH_DREQ_TIMING 4
`define SCI_ENH_TX_LEVEL 5
// Master control fields.
`define SCI_MASTER_MIE 3
`define SCI_MASTER_NO_VEC 1
// Command codes.
`define SCI_CMD_RESET_IUS 8'h38
`define SCI_CMD_SOFT_ACK 8'h2c
`define SCI_CMD_FIRST_RX 8'h20
`define SCI_RST_CTRL 8'h00
`define SCI_RST_VECTOR 8'h00
`define SCI_RX_FULL_LEVEL 3'd4
`endif

// *** design/sci_pkg.sv ***
package sci_pkg;
	typedef enum logic [1:0] {
		SCI_RX_OFF,
		SCI_RX_FIRST,
		SCI_RX_ALL,
		SCI_RX_SPECIAL
	} sci_rx_mode_type;
	typedef enum {
		SCI_ACK_IDLE,
		SCI_ACK_ACTIVE
	} sci_ack_state_type;
endpackage

// *** test/sci_irq_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sci_irq_ctrl_monitor (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic chain_enable_input,
	input wire logic chain_enable_output,
	input wire logic irq_acknowledge_n,
	input wire logic irq_n_o,
	input wire logic irq_n_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_grant;
		$fell(irq_acknowledge_n) ##0 irq_n_oe;
	endsequence
	chk_bus_answer: assert property (s_take |=> wb_ack_o || wb_err_o)
		else $error("bus request not answered");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_resp_excl: assert property (!(wb_ack_o && wb_err_o))
		else $error("ack and err together");
	chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_open_drain: assert property (irq_n_oe |-> irq_n_o == 1'b0)
		else $error("request pin driven high");
	// The chain input passes two sync stages, so five low samples cover the lag.
	chk_chain_gate: assert property (!chain_enable_input [*5] |-> !chain_enable_output)
		else $error("chain output high without chain input");
	chk_chain_irq: assert property (!chain_enable_input [*5] |-> !irq_n_oe)
		else $error("request raised without chain input");
	chk_grant_release: assert property (s_grant |-> ##[1:8] !irq_n_oe)
		else $error("request not released by acknowledge");
	chk_grant_chain: assert property (s_grant |-> ##[1:8] !chain_enable_output)
		else $error("chain output not lowered by acknowledge");
endmodule
`default_nettype wire

// *** test/sci_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sci_host_model (
	input wire logic ref_clk,
	input wire logic irq_n_oe,
	input wire logic grant_en,
	input wire logic [3:0] grant_delay,
	output logic irq_acknowledge_n
);
	logic irq_line;
	// The request line has a pull-up, so it is high whenever nobody drives it.
	assign irq_line = irq_n_oe ? 1'b0 : 1'b1;
	initial begin
		irq_acknowledge_n = 1'b1;
		forever begin
			@(posedge ref_clk);
			if (grant_en && !irq_line) begin
				repeat (grant_delay) @(posedge ref_clk);
				irq_acknowledge_n <= 1'b0;
				repeat (10) @(posedge ref_clk);
				irq_acknowledge_n <= 1'b1;
				repeat (4) @(posedge ref_clk);
			end
		end
	end
endmodule
`default_nettype wire

// *** test/sci_irq_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sci_regs.svh"
module sci_irq_ctrl_tb_top;
	logic ref_clk, nrst, cyc, stb, we, chain_in, gnt_en, ack_n, irq_o, irq_oe, chain_out, ack, err, e;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [1:0] pl [0:9];
	logic [1:0] pin [0:3];
	logic [1:0] wrq_n, drq_n;
	logic [5:0] fcnt;
	logic [3:0] gdly;
	int miscompares, num_checks;
	sci_irq_ctrl dut (.ref_clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.chain_enable_input(chain_in), .chain_enable_output(chain_out), .irq_acknowledge_n(ack_n),
		.irq_n_o(irq_o), .irq_n_oe(irq_oe), .rx_char_avail(pl[0]), .rx_fifo_count(fcnt), .rx_overrun(pl[1]),
		.rx_framing_err(pl[2]), .rx_end_of_frame(pl[3]), .rx_parity_err(pl[4]), .tx_top_empty(pl[5]),
		.tx_all_empty(pl[6]), .tx_written(pl[7]), .cts_n(pin[0]), .carrier_detect_input_n(pin[1]),
		.sync_n(pin[2]), .tx_underrun(pl[8]), .brg_zero(pl[9]), .break_abort_eop(pin[3]),
		.wait_request_n(wrq_n), .dma_request2_n(drq_n));
	sci_host_model host (.ref_clk, .irq_n_oe(irq_oe), .grant_en(gnt_en), .grant_delay(gdly),
		.irq_acknowledge_n(ack_n));
	function automatic logic [31:0] ones(input logic [31:0] v);
		return 32'($countones(v));
	endfunction
	function automatic logic [31:0] rx_exp(input int m, input logic lv, input logic [2:0] c);
		return {31'h0, (m == 1 || m == 2) && (!lv || c >= `SCI_RX_FULL_LEVEL)};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk);
		end while (!(ack || err));
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic pulse(input int k, input int ch);
		pl[k][ch] <= 1'b1;
		@(posedge ref_clk);
		pl[k][ch] <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic tog(input int k);
		pin[k][0] <= ~pin[k][0];
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic serve(output logic [7:0] s);
		wb(1, `SCI_ADDR_COMMAND, {24'h0, `SCI_CMD_SOFT_ACK});
		wb(0, `SCI_ADDR_SERVICE, 0);
		s = q[7:0];
		wb(1, `SCI_ADDR_COMMAND, {24'h0, `SCI_CMD_RESET_IUS});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#500000;
		miscompares++;
		summarize();
	end
	initial begin
		logic [7:0] pb, pab, s;
		logic lv;
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		chain_in = 1'b1;
		gnt_en = 1'b0;
		gdly = 4'h0;
		fcnt = 6'h00;
		foreach (pl[i]) pl[i] = 2'b00;
		foreach (pin[i]) pin[i] = 2'b11;
		void'($urandom(32'h5599c772));
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("wait idle", wrq_n, 2'b11);
		chk("drq idle", drq_n, 2'b11);
		wb(0, `SCI_ADDR_CTRL_A, 0);
		chk("ctrl reset", q, `SCI_RST_CTRL);
		wb(0, 8'h3c, 0);
		chk("unmapped err", e, 1'b1);
		wb(1, `SCI_ADDR_MASTER, 32'h8);
		pulse(5, 0);
		pulse(1, 0);
		wb(0, `SCI_ADDR_PEND, 0);
		chk("no enable", q, 0);
		$display("reset and enable test done");
		wb(1, `SCI_ADDR_CTRL_A, 32'h2);
		wb(1, `SCI_ADDR_CTRL_B, 32'h2);
		pulse(5, 1);
		wb(0, `SCI_ADDR_PEND, 0);
		pb = q[7:0];
		chk("one pending", ones(pb), 1);
		chk("irq", irq_oe, 1'b1);
		chain_in <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("irq chain low", irq_oe, 1'b0);
		chk("chain out low", chain_out, 1'b0);
		chain_in <= 1'b1;
		pulse(5, 0);
		wb(0, `SCI_ADDR_PEND, 0);
		pab = q[7:0];
		chk("two pending", ones(pab), 2);
		gdly <= 4'($urandom_range(0, 7));
		gnt_en <= 1'b1;
		repeat (30) @(posedge ref_clk);
		gnt_en <= 1'b0;
		wb(0, `SCI_ADDR_SERVICE, 0);
		chk("channel a first", q[7:0], pab ^ pb);
		chk("chain held", chain_out, 1'b0);
		chk("lower blocked", irq_oe, 1'b0);
		wb(1, `SCI_ADDR_COMMAND, {24'h0, `SCI_CMD_RESET_IUS});
		repeat (6) @(posedge ref_clk);
		chk("lower released", irq_oe, 1'b1);
		serve(s);
		chk("soft ack", s, pb);
		repeat (6) @(posedge ref_clk);
		chk("chain free", chain_out, 1'b1);
		$display("priority test done");
		wb(1, `SCI_ADDR_VECTOR, 32'ha5);
		wb(0, `SCI_ADDR_VEC_A, 0);
		chk("vector a", q, 32'ha5);
		wb(0, `SCI_ADDR_VEC_B, 0);
		chk("vector b", {q[7:4], q[0]}, 5'h15);
		wb(1, `SCI_ADDR_MASTER, 0);
		pulse(5, 0);
		chk("master off", irq_oe, 1'b0);
		wb(1, `SCI_ADDR_MASTER, 32'h8);
		repeat (6) @(posedge ref_clk);
		chk("master on", irq_oe, 1'b1);
		serve(s);
		wb(1, `SCI_ADDR_ENH_A, 32'h20);
		pulse(5, 0);
		pulse(6, 0);
		wb(0, `SCI_ADDR_PEND, 0);
		chk("tx not empty", q, 0);
		pl[7][0] <= 1'b1;
		pulse(6, 0);
		pl[7][0] <= 1'b0;
		wb(0, `SCI_ADDR_PEND, 0);
		chk("tx empty", ones(q), 1);
		serve(s);
		wb(1, `SCI_ADDR_ENH_A, 0);
		$display("master and transmit test done");
		for (int m = 1; m < 4; m++) begin
			lv = (m == 2) ? 1'($urandom_range(0, 1)) : 1'b0;
			// Switching the receiver off first drops a level-held request left by the last pass.
			wb(1, `SCI_ADDR_CTRL_A, 0);
			fcnt <= 6'($urandom_range(0, 7));
			wb(1, `SCI_ADDR_CTRL_A, 32'(m << 3) | 32'h4);
			wb(1, `SCI_ADDR_ENH_A, {28'h0, lv, 3'h0});
			wb(1, `SCI_ADDR_COMMAND, {24'h0, `SCI_CMD_FIRST_RX});
			pulse(0, 0);
			wb(0, `SCI_ADDR_PEND, 0);
			chk("rx char", ones(q), rx_exp(m, lv, fcnt[2:0]));
			serve(s);
			pulse($urandom_range(1, 4), 0);
			wb(0, `SCI_ADDR_PEND, 0);
			chk("rx special", ones(q), 1);
			serve(s);
		end
		$display("receive test done");
		wb(1, `SCI_ADDR_CTRL_A, 32'h1);
		for (int k = 0; k < 7; k++) begin
			if (k < 5)
				tog(k < 4 ? k : 3);
			else
				pulse(k + 3, 0);
			wb(0, `SCI_ADDR_PEND, 0);
			chk("ext event", ones(q), 1);
			serve(s);
		end
		$display("external status test done");
		wb(1, `SCI_ADDR_CTRL_A, 32'he0);
		pl[0][0] <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("dma request", wrq_n[0], 1'b0);
		pl[0][0] <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("dma idle", wrq_n[0], 1'b1);
		wb(1, `SCI_ADDR_CTRL_A, 32'h80);
		repeat (6) @(posedge ref_clk);
		chk("cpu wait", wrq_n[0], 1'b0);
		wb(1, `SCI_ADDR_ENH_A, 32'h10);
		pl[5][0] <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("cpu ready", wrq_n[0], 1'b1);
		chk("second request", drq_n[0], 1'b0);
		pl[5][0] <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("second idle", drq_n[0], 1'b1);
		$display("block transfer test done");
		summarize();
	end
endmodule
bind sci_irq_ctrl sci_irq_ctrl_monitor mon (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.wb_err_o, .chain_enable_input, .chain_enable_output, .irq_acknowledge_n, .irq_n_o, .irq_n_oe);
`default_nettype wire
